// [common/urw_pkg.sv]
// urw_pkg: constants and carrier types for the idle-polarity uart receiver
// assumes a 50 MHz reference clock; no software-visible registers
package urw_pkg;
  localparam int unsigned REF_CLK_HZ = 50000000;
  localparam int unsigned BAUD_DEFAULT = 115200;
  // 16 samples per bit
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned POL_BIT = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [3:0] LAST_SAMPLE = 4'hf;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int unsigned DIV_W = 16;

  typedef struct packed {
    logic [7:0] data;
    logic framing_err;
    logic wake_char;
  } urw_rx_char_t;
endpackage : urw_pkg

// [src/urw_rx.sv]
// urw_rx: uart receiver with selectable idle level and sleep clock gating
// assumes the receive pin is asynchronous and a system sleep request level
`timescale 1ns/1ps

// How it works
// - mode bit 4 selects idle level
// - bit resets 0, line idles high
// - any idle departure lasting two clocks or more starts start detection
// - sampling clock stopped during sleep
// - pin activity wakes; first char after wake is still delivered with rx_valid_q, flagged wake_char
module urw_rx #(
  parameter int unsigned BAUD_DIV = urw_pkg::REF_CLK_HZ / (urw_pkg::BAUD_DEFAULT * urw_pkg::OVERSAMPLE)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] uart_mode_register,
  input wire logic sleep_req,
  input wire logic uart_receive_pin,
  output logic wake_q,
  output logic rx_valid_q,
  output urw_pkg::urw_rx_char_t rx_char_q
);
  typedef enum logic [1:0] {URW_IDLE, URW_START, URW_DATA, URW_STOP} urw_state_t;

  localparam logic [urw_pkg::DIV_W-1:0] DIV_LAST = urw_pkg::DIV_W'(BAUD_DIV - 1);

  logic [2:0] pin_sync_q;
  logic pin_stable_q;
  logic [7:0] mode_q;
  logic asleep_q;
  logic wake_pending_q;
  logic [urw_pkg::DIV_W-1:0] div_q;
  logic tick_q;
  urw_state_t state_q;
  logic [3:0] samp_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;

  // three-stage sync; change accepted when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 3'h7;
      pin_stable_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], uart_receive_pin};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_stable_q <= pin_sync_q[2];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= urw_pkg::MODE_RESET;
    end else begin
      mode_q <= uart_mode_register;
    end
  end

  wire invert = mode_q[urw_pkg::POL_BIT];
  // line in "active-high idle" form regardless of polarity
  wire rx_line = pin_stable_q ^ invert;
  wire rx_active = !rx_line;

  // sleep stops the sampling clock; only the synchronized wake detector keeps running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep_q <= 1'b0;
      wake_q <= 1'b0;
      wake_pending_q <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      if (asleep_q && rx_active) begin
        asleep_q <= 1'b0;
        wake_q <= 1'b1;
        wake_pending_q <= 1'b1;
      end else if (sleep_req && !asleep_q) begin
        asleep_q <= 1'b1;
      end else if (rx_valid_q) begin
        wake_pending_q <= 1'b0;
      end
    end
  end

  wire run = !asleep_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (!run) begin
        div_q <= '0;
      end else if (div_q == DIV_LAST) begin
        div_q <= '0;
        tick_q <= 1'b1;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  wire mid = tick_q && (samp_q == urw_pkg::MID_SAMPLE);
  wire bit_end = tick_q && (samp_q == urw_pkg::LAST_SAMPLE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= URW_IDLE;
      samp_q <= '0;
      bit_q <= '0;
      shift_q <= '0;
      rx_valid_q <= 1'b0;
      rx_char_q <= '0;
    end else begin
      rx_valid_q <= 1'b0;
      if (tick_q) begin
        samp_q <= samp_q + 4'h1;
      end
      if (!run) begin
        state_q <= URW_IDLE;
        samp_q <= '0;
      end else begin
        case (state_q)
          URW_IDLE: begin
            samp_q <= '0;
            if (rx_active) begin
              state_q <= URW_START;
            end
          end
          URW_START: begin
            // glitch shorter than half a bit returns to idle
            if (mid && !rx_active) begin
              state_q <= URW_IDLE;
            end else if (bit_end) begin
              state_q <= URW_DATA;
              bit_q <= '0;
            end
          end
          URW_DATA: begin
            if (mid) begin
              shift_q <= {rx_line, shift_q[7:1]};
            end
            if (bit_end) begin
              if (bit_q == urw_pkg::LAST_BIT) begin
                state_q <= URW_STOP;
              end
              bit_q <= bit_q + 3'h1;
            end
          end
          URW_STOP: begin
            if (mid) begin
              rx_valid_q <= 1'b1;
              rx_char_q.data <= shift_q;
              rx_char_q.framing_err <= !rx_line;
              rx_char_q.wake_char <= wake_pending_q;
              state_q <= URW_IDLE;
            end
          end
          default: state_q <= URW_IDLE;
        endcase
      end
    end
  end

  property p_pol_reset;
    @(posedge ref_clk) $rose(rst_n) |-> !mode_q[urw_pkg::POL_BIT];
  endproperty
  a_pol_reset: assert property (p_pol_reset) else $error("polarity not zero after reset");

  property p_idle_start;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_q == URW_IDLE && run && rx_active) |=> (state_q == URW_START || !run);
  endproperty
  a_idle_start: assert property (p_idle_start) else $error("activity did not start detection");

  property p_pol_line;
    @(posedge ref_clk) disable iff (!rst_n) rx_active == (invert ? pin_stable_q : !pin_stable_q);
  endproperty
  a_pol_line: assert property (p_pol_line) else $error("activity level ignores polarity");

  property p_sleep_stop;
    @(posedge ref_clk) disable iff (!rst_n) asleep_q |=> !tick_q;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("sampling tick during sleep");

  sequence s_wake;
    asleep_q && rx_active;
  endsequence
  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n) s_wake |=> (wake_q && wake_pending_q && !asleep_q);
  endproperty
  a_wake: assert property (p_wake) else $error("pin activity did not wake");

  property p_resync;
    @(posedge ref_clk) disable iff (!rst_n) rx_valid_q |=> (state_q == URW_IDLE || state_q == URW_START);
  endproperty
  a_resync: assert property (p_resync) else $error("no return to start search");
endmodule : urw_rx

// [verif/urw_line_model.sv]
// urw_line_model: remote uart node on the shared receive line
// assumes 8n1 frames and a pull resistor matching the idle level
`timescale 1ns/1ps
module urw_line_model #(
  parameter int BIT_CYC = 32
) (
  input wire logic ref_clk,
  input wire logic inv,
  output logic line
);
  logic drv_en = 1'b0;
  logic drv_val = 1'b1;
  // released line rests at the pulled idle level
  // idle is high with polarity 0 and low with polarity 1
  assign line = drv_en ? drv_val : ~inv;

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      drv_en <= 1'b1;
      drv_val <= f[i] ^ inv;
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    drv_en <= 1'b0;
  endtask : send

  // short departure from idle, too brief to be a start bit
  task automatic pulse(input int n);
    @(posedge ref_clk);
    drv_en <= 1'b1;
    drv_val <= inv;
    repeat (n) @(posedge ref_clk);
    drv_en <= 1'b0;
  endtask : pulse
endmodule : urw_line_model

// [verif/tb_urw_rx.sv]
// tb_urw_rx: self-checking bench for the idle-polarity receiver
// assumes BAUD_DIV 2, so one bit lasts 32 reference clocks
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb_urw_rx;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_req = 1'b0;
  logic [7:0] mode = 8'h00;
  logic pin;
  logic wake_q;
  logic rx_valid_q;
  urw_pkg::urw_rx_char_t rx_char_q;
  logic [10:0] q[$];
  logic [10:0] e;
  int err_total = 0;
  int tests_run = 0;
  int seed = 6003;
  int wakes = 0;

  always #10 ref_clk = ~ref_clk;

  urw_rx #(.BAUD_DIV(2)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .uart_mode_register(mode),
    .sleep_req(sleep_req), .uart_receive_pin(pin), .wake_q(wake_q), .rx_valid_q(rx_valid_q),
    .rx_char_q(rx_char_q));
  urw_line_model #(.BIT_CYC(32)) m (.ref_clk(ref_clk), .inv(mode[4]), .line(pin));

  // note holds {check data, data, framing error, wake flag}
  task automatic tx(input logic [7:0] b, input logic w);
    q.push_back({~w, b, 1'b0, w});
    m.send(b);
  endtask : tx

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  always @(posedge ref_clk) begin
    if (wake_q) wakes++;
    if (rx_valid_q) begin
      if (q.size() == 0) `CHK("spurious char", 1'b0, 1'b1)
      else begin
        e = q.pop_front();
        // wake char payload is garbage by nature, only its flag counts
        if (e[10]) `CHK("data", e[9:2], rx_char_q.data)
        if (e[10]) `CHK("framing", e[1], rx_char_q.framing_err)
        `CHK("wake flag", e[0], rx_char_q.wake_char)
      end
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int p = 0; p < 2; p++) begin
      mode <= (8'($random(seed)) & 8'hef) | (p ? 8'h10 : 8'h00);
      repeat (40) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) tx(8'($random(seed)), 1'b0);
      m.pulse(3);
      repeat (64) @(posedge ref_clk);
    end
    sleep_req <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    repeat (20) @(posedge ref_clk);
    tx(8'($random(seed)), 1'b1);
    tx(8'($random(seed)), 1'b0);
    repeat (64) @(posedge ref_clk);
    `CHK("wake pulses", 1, wakes)
    `CHK("notes left", 0, q.size())
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end
endmodule : tb_urw_rx
